// >>> core/gtm_defs.vh
// register map, field positions and encodings of the general timer module
`ifndef GTM_DEFS_VH
`define GTM_DEFS_VH
// register byte addresses on the axi4-lite bus
`define GTM_OFF_CTRL0 6'h00
`define GTM_OFF_CTRL1 6'h04
`define GTM_OFF_CNTL 6'h08
`define GTM_OFF_CNTH 6'h0c
`define GTM_OFF_CMPL 6'h10
`define GTM_OFF_CMPH 6'h14
`define GTM_OFF_PINSEL 6'h18
`define GTM_OFF_STAT 6'h1c
// timer_control_zero fields
`define GTM_C0_PAUSE 7
`define GTM_C0_CKS_HI 6
`define GTM_C0_CKS_LO 4
`define GTM_C0_ON 3
`define GTM_C0_RP_HI 2
`define GTM_C0_RP_LO 0
// timer_control_one fields
`define GTM_C1_MODE_HI 7
`define GTM_C1_MODE_LO 6
`define GTM_C1_IO_HI 5
`define GTM_C1_IO_LO 4
`define GTM_C1_OC 3
`define GTM_C1_POL 2
`define GTM_C1_DPX 1
`define GTM_C1_CCLR 0
// pin select bits
`define GTM_PS_CLK 0
`define GTM_PS_CAP 1
`define GTM_PS_OUT 2
`define GTM_PS_OUTN 3
// status bits, write one to clear
`define GTM_ST_MA 0
`define GTM_ST_MP 1
`define GTM_ST_CAP 2
// operating modes
`define GTM_MODE_CMP 2'h0
`define GTM_MODE_CAP 2'h1
`define GTM_MODE_PWM 2'h2
`define GTM_MODE_TMR 2'h3
// clock selections
`define GTM_CK_SYS4 3'h0
`define GTM_CK_SYS 3'h1
`define GTM_CK_H16 3'h2
`define GTM_CK_H64 3'h3
`define GTM_CK_TBC0 3'h4
`define GTM_CK_TBC1 3'h5
`define GTM_CK_EXTR 3'h6
`define GTM_CK_EXTF 3'h7
// reset values
`define GTM_RST_CTRL 8'h00
`define GTM_RST_PINSEL 4'h0
// counter width and system clock divider terminal count
`define GTM_CNT_W 10
`define GTM_SYS_DIV 2'h3
`endif

// >>> core/gtm_edge_det.v
// synchroniser and edge detector for one timer input pin
`timescale 1ns/1ps
module gtm_edge_det (
   // clock and reset
   input wire aclk,
   input wire aresetn,
   // pin and gating
   input wire pin_in,
   input wire enable,
   // edge pulses
   output wire rise,
   output wire fall
);
   reg sync1_q;
   reg sync2_q;
   reg last_q;
   // two-stage synchroniser, then a history flop for edges
   always @(posedge aclk) begin
      if (!aresetn) begin
         sync1_q <= 1'b0;
         sync2_q <= 1'b0;
         last_q <= 1'b0;
      end else begin
         sync1_q <= pin_in;
         sync2_q <= sync1_q;
         last_q <= sync2_q;
      end
   end
   // one pulse per qualifying edge; gated so an unselected pin does nothing
   assign rise = enable & sync2_q & ~last_q;
   assign fall = enable & ~sync2_q & last_q;
endmodule

// >>> core/gtm_timer.v
// general timer module: 10-bit counter, two comparators, capture, pwm, axi4-lite slave
// Overview of operation
// - counter matching a comparator raises a request, may clear counter, change output
// - comparator a and comparator p each give their own interrupt source
// - three-bit clock select picks system, high, timebase or external clock
// - external count pin drives the counter only when clock select chooses it
// - external pin counts on rising or falling edge as configured
// - capture input triggers on rising, falling or both edges per pin function select
// - compare match output mode drives output high, low, or toggles on match
// - edge aligned pwm appears on the primary output, duty or period adjustable
// - one pin select bit per timer pin connects it to the timer
// - high bytes accessed directly, low bytes only via shared 8-bit buffer
// - buffer transfers happen only on high byte access, never low byte access
// - compare a low byte write loads only the buffer
// - compare a high byte write also copies buffer into compare a low byte
// - high byte read returns high byte and copies low byte into buffer
// - low byte read returns the holding buffer, not the live low byte
// - the core is a 10-bit up counter on the selected clock
// - secondary output always carries the inverse of the primary output
// - software clears the counter only by raising the counter-on bit
// - counter also clears on overflow or on a match of the comparator that the counter clear bit selects
//
// The AXI4-Lite register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`include "gtm_defs.vh"
module gtm_timer #(
   parameter H_DIV16 = 16,
   parameter H_DIV64 = 64
) (
   // clock and reset
   input wire aclk,
   input wire aresetn,
   // other internal clock sources, one-cycle enable pulses
   input wire high_clk_tick,
   input wire timebase_tick,
   // timer pins
   input wire ext_count_clock_pin,
   input wire capture_input_pin,
   output reg timer_output_pin,
   output reg timer_output_pin_en,
   output reg timer_output_pin_inverted,
   output reg timer_output_pin_inverted_en,
   // interrupt requests
   output reg irq_compare_a,
   output reg irq_compare_p,
   // axi4-lite write address and data
   input wire [5:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   // axi4-lite write response
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   // axi4-lite read
   input wire [5:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready
);
   localparam CW = `GTM_CNT_W;
   // prescaler terminal counts, kept at 32 bits so the slices below are exact
   localparam [31:0] H16_LAST = H_DIV16 - 1;
   localparam [31:0] H64_LAST = H_DIV64 - 1;
   reg [7:0] ctrl0_q;
   reg [7:0] ctrl1_q;
   reg [3:0] pinsel_q;
   reg [2:0] stat_q;
   reg [CW-1:0] count_q;
   reg [CW-1:0] cmpa_q;
   reg [CW-1:0] cap_q;
   reg [7:0] hold_q;
   reg out_q;
   reg on_last_q;
   reg pulse_done_q;
   reg [1:0] sys_div_q;
   reg [5:0] h_div_q;
   reg h16_q;
   reg h64_q;
   reg [5:0] aw_addr_q;
   reg aw_have_q;
   reg [31:0] w_data_q;
   reg [3:0] w_strb_q;
   reg w_have_q;
   wire [2:0] cks = ctrl0_q[`GTM_C0_CKS_HI:`GTM_C0_CKS_LO];
   wire [1:0] mode = ctrl1_q[`GTM_C1_MODE_HI:`GTM_C1_MODE_LO];
   wire [1:0] io = ctrl1_q[`GTM_C1_IO_HI:`GTM_C1_IO_LO];
   wire [2:0] rp = ctrl0_q[`GTM_C0_RP_HI:`GTM_C0_RP_LO];
   wire on = ctrl0_q[`GTM_C0_ON];
   wire ext_sel = (cks == `GTM_CK_EXTR) || (cks == `GTM_CK_EXTF);

   // selects a register by its byte address
   function is_reg;
      input [5:0] addr;
      input [5:0] off;
      begin
         is_reg = (addr == off);
      end
   endfunction

   // input pins, connected to the timer only when selected
   wire ext_rise;
   wire ext_fall;
   wire cap_rise;
   wire cap_fall;
   gtm_edge_det u_ext (
      .aclk(aclk),
      .aresetn(aresetn),
      .pin_in(ext_count_clock_pin),
      .enable(pinsel_q[`GTM_PS_CLK] & ext_sel),
      .rise(ext_rise),
      .fall(ext_fall)
   );
   gtm_edge_det u_cap (
      .aclk(aclk),
      .aresetn(aresetn),
      .pin_in(capture_input_pin),
      .enable(pinsel_q[`GTM_PS_CAP]),
      .rise(cap_rise),
      .fall(cap_fall)
   );

   // prescalers for the internal clock ratios
   always @(posedge aclk) begin
      if (!aresetn) begin
         sys_div_q <= 2'h0;
         h_div_q <= 6'h00;
         h16_q <= 1'b0;
         h64_q <= 1'b0;
      end else begin
         sys_div_q <= sys_div_q + 2'h1;
         h16_q <= 1'b0;
         h64_q <= 1'b0;
         if (high_clk_tick) begin
            h_div_q <= h_div_q + 6'h01;
            h16_q <= (h_div_q[3:0] == H16_LAST[3:0]);
            h64_q <= (h_div_q == H64_LAST[5:0]);
         end
      end
   end

   // counter clock enable from the clock select field
   reg tick;
   always @* begin
      case (cks)
         `GTM_CK_SYS4: tick = (sys_div_q == `GTM_SYS_DIV);
         `GTM_CK_SYS: tick = 1'b1;
         `GTM_CK_H16: tick = h16_q;
         `GTM_CK_H64: tick = h64_q;
         `GTM_CK_TBC0, `GTM_CK_TBC1: tick = timebase_tick;
         `GTM_CK_EXTR: tick = ext_rise;
         `GTM_CK_EXTF: tick = ext_fall;
         default: tick = 1'b0;
      endcase
   end

   // comparators; a period value of zero means a full 1024-count period
   wire run = on & ~ctrl0_q[`GTM_C0_PAUSE] & tick;
   wire match_a = run && (count_q == cmpa_q);
   wire match_p = run && (rp == 3'h0 ? count_q == {CW{1'b1}} :
                          (count_q[CW-1:CW-3] == rp && count_q[CW-4:0] == 7'h00));
   wire overflow = run && (count_q == {CW{1'b1}});
   wire clr_sel = ctrl1_q[`GTM_C1_CCLR] ? match_a : match_p;
   wire on_rise = on & ~on_last_q;
   wire cap_evt = (mode == `GTM_MODE_CAP) && ((io == 2'h0 && cap_rise) ||
                  (io == 2'h1 && cap_fall) || (io == 2'h2 && (cap_rise | cap_fall)));

   // 10-bit up counter; software can only clear it via the on bit
   always @(posedge aclk) begin
      if (!aresetn) begin
         count_q <= {CW{1'b0}};
         on_last_q <= 1'b0;
      end else begin
         on_last_q <= on;
         if (on_rise)
            count_q <= {CW{1'b0}};
         else if (clr_sel || overflow)
            count_q <= {CW{1'b0}};
         else if (run)
            count_q <= count_q + 1'b1;
      end
   end

   // output pin level per mode; polarity bit inverts the pin
   wire act = ~ctrl1_q[`GTM_C1_OC];
   always @(posedge aclk) begin
      if (!aresetn) begin
         out_q <= 1'b0;
         pulse_done_q <= 1'b0;
      end else if (on_rise) begin
         out_q <= ctrl1_q[`GTM_C1_OC];
         pulse_done_q <= 1'b0;
      end else begin
         case (mode)
            `GTM_MODE_CMP: begin
               if (match_a) begin
                  case (io)
                     2'h1: out_q <= 1'b0;
                     2'h2: out_q <= 1'b1;
                     2'h3: out_q <= ~out_q;
                     default: out_q <= out_q;
                  endcase
               end
            end
            `GTM_MODE_PWM: begin
               case (io)
                  2'h0: out_q <= ~act;
                  2'h1: out_q <= act;
                  2'h2: begin
                     // edge aligned: duty from one comparator, period from the other
                     if (ctrl1_q[`GTM_C1_DPX] ? match_a : match_p)
                        out_q <= act;
                     else if (ctrl1_q[`GTM_C1_DPX] ? match_p : match_a)
                        out_q <= ~act;
                  end
                  default: begin
                     if (on && !pulse_done_q) begin
                        out_q <= act;
                        pulse_done_q <= 1'b1;
                     end else if (match_a)
                        out_q <= ~act;
                  end
               endcase
            end
            default: out_q <= out_q;
         endcase
      end
   end

   // pins driven only when their select bits give them to the timer
   always @(posedge aclk) begin
      if (!aresetn) begin
         timer_output_pin <= 1'b0;
         timer_output_pin_inverted <= 1'b1;
         timer_output_pin_en <= 1'b0;
         timer_output_pin_inverted_en <= 1'b0;
         irq_compare_a <= 1'b0;
         irq_compare_p <= 1'b0;
      end else begin
         timer_output_pin <= out_q ^ ctrl1_q[`GTM_C1_POL];
         timer_output_pin_inverted <= ~(out_q ^ ctrl1_q[`GTM_C1_POL]);
         timer_output_pin_en <= pinsel_q[`GTM_PS_OUT];
         timer_output_pin_inverted_en <= pinsel_q[`GTM_PS_OUTN];
         irq_compare_a <= match_a | (cap_evt & ctrl1_q[`GTM_C1_CCLR]);
         irq_compare_p <= match_p;
      end
   end

   // axi handshake: each channel is taken once, answer waits for the old one to drain
   assign s_axi_awready = ~aw_have_q & ~s_axi_bvalid;
   assign s_axi_wready = ~w_have_q & ~s_axi_bvalid;
   assign s_axi_arready = ~s_axi_rvalid;
   wire wr_go = aw_have_q & w_have_q;
   wire rd_go = s_axi_arvalid & s_axi_arready;
   wire wr_hi_ok = w_strb_q[0];
   wire [7:0] wd = w_data_q[7:0];
   wire [1:0] mem_bits = wd[1:0];

   // register file, holding buffer and status
   always @(posedge aclk) begin
      if (!aresetn) begin
         ctrl0_q <= `GTM_RST_CTRL;
         ctrl1_q <= `GTM_RST_CTRL;
         pinsel_q <= `GTM_RST_PINSEL;
         cmpa_q <= {CW{1'b0}};
         cap_q <= {CW{1'b0}};
         hold_q <= 8'h00;
         stat_q <= 3'h0;
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         aw_addr_q <= 6'h00;
         w_data_q <= 32'h0000_0000;
         w_strb_q <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'h0;
         s_axi_rvalid <= 1'b0;
         s_axi_rresp <= 2'h0;
         s_axi_rdata <= 32'h0000_0000;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
         end
         if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
         if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
         // capture latches the counter into cap_q, read back through the compare a pair
         if (cap_evt) begin
            cap_q <= count_q;
            stat_q[`GTM_ST_CAP] <= 1'b1;
         end
         // status sticky bits; write-one-to-clear loses to a new event
         if (wr_go && is_reg(aw_addr_q, `GTM_OFF_STAT) && wr_hi_ok)
            stat_q <= stat_q & ~wd[2:0] | {cap_evt, match_p, match_a};
         else
            stat_q <= stat_q | {cap_evt, match_p, match_a};
         if (wr_go) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= 2'h0;
            if (wr_hi_ok) begin
               if (is_reg(aw_addr_q, `GTM_OFF_CTRL0))
                  ctrl0_q <= wd;
               else if (is_reg(aw_addr_q, `GTM_OFF_CTRL1))
                  ctrl1_q <= wd;
               else if (is_reg(aw_addr_q, `GTM_OFF_PINSEL))
                  pinsel_q <= wd[3:0];
               else if (is_reg(aw_addr_q, `GTM_OFF_CMPL))
                  hold_q <= wd;
               else if (is_reg(aw_addr_q, `GTM_OFF_CMPH))
                  cmpa_q <= {mem_bits, hold_q};
               else if (!is_reg(aw_addr_q, `GTM_OFF_STAT) &&
                        !is_reg(aw_addr_q, `GTM_OFF_CNTL) &&
                        !is_reg(aw_addr_q, `GTM_OFF_CNTH))
                  s_axi_bresp <= 2'h2;
            end
         end
         if (rd_go) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= 2'h0;
            s_axi_rdata <= 32'h0000_0000;
            case (s_axi_araddr)
               `GTM_OFF_CTRL0: s_axi_rdata[7:0] <= ctrl0_q;
               `GTM_OFF_CTRL1: s_axi_rdata[7:0] <= ctrl1_q;
               `GTM_OFF_PINSEL: s_axi_rdata[3:0] <= pinsel_q;
               `GTM_OFF_STAT: s_axi_rdata[2:0] <= stat_q;
               `GTM_OFF_CNTL, `GTM_OFF_CMPL: s_axi_rdata[7:0] <= hold_q;
               `GTM_OFF_CNTH: begin
                  s_axi_rdata[1:0] <= count_q[CW-1:8];
                  hold_q <= count_q[7:0];
               end
               `GTM_OFF_CMPH: begin
                  // in capture mode the compare a pair shows the captured value
                  s_axi_rdata[1:0] <= (mode == `GTM_MODE_CAP) ? cap_q[CW-1:8] : cmpa_q[CW-1:8];
                  hold_q <= (mode == `GTM_MODE_CAP) ? cap_q[7:0] : cmpa_q[7:0];
               end
               default: s_axi_rresp <= 2'h2;
            endcase
         end
      end
   end
endmodule

// >>> tb/gtm_timer_properties.sv
// assertion checker watching the general timer module ports
`timescale 1ns/1ps
module gtm_timer_properties (
   // clock and reset
   input wire aclk,
   input wire aresetn,
   // pins and requests
   input wire timer_output_pin,
   input wire timer_output_pin_inverted,
   input wire irq_compare_p,
   // register bus
   input wire s_axi_awvalid,
   input wire s_axi_awready,
   input wire s_axi_wvalid,
   input wire s_axi_wready,
   input wire [1:0] s_axi_bresp,
   input wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire [5:0] s_axi_araddr,
   input wire s_axi_arvalid,
   input wire s_axi_arready,
   input wire [31:0] s_axi_rdata,
   input wire [1:0] s_axi_rresp,
   input wire s_axi_rvalid,
   input wire s_axi_rready
);
   reg [5:0] ar_q;
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // last accepted read address, to judge the response it earns
   always @(posedge aclk) begin
      if (!aresetn)
         ar_q <= 6'h00;
      else if (s_axi_arvalid && s_axi_arready)
         ar_q <= s_axi_araddr;
   end
   a_inv_output: assert property (timer_output_pin_inverted == !timer_output_pin)
      else $error("inverted output equals primary output");
   a_irq_p_pulse: assert property (irq_compare_p |=> !irq_compare_p)
      else $error("compare p request longer than one cycle");
   a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped before taken");
   a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped before taken");
   a_write_resp_lat: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##[1:2] s_axi_bvalid) else $error("write response late");
   a_read_resp_lat: assert property (s_axi_arvalid && s_axi_arready |=> ##[0:1] s_axi_rvalid)
      else $error("read response late");
   a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read address taken while data pending");
   a_aw_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while response pending");
   a_bad_addr_err: assert property ($rose(s_axi_rvalid) && ar_q >= 6'h20
      |-> s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0) else $error("unmapped read not refused");
endmodule
bind gtm_timer gtm_timer_properties chk_u (.aclk, .aresetn, .timer_output_pin,
   .timer_output_pin_inverted, .irq_compare_p, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
   .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
   .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

// >>> tb/gtm_axi_master.sv
// axi4-lite master model standing in for the cpu software
`timescale 1ns/1ps
module gtm_axi_master (
   // clock
   input wire aclk,
   // write side
   output reg [5:0] s_axi_awaddr,
   output reg s_axi_awvalid,
   input wire s_axi_awready,
   output reg [31:0] s_axi_wdata,
   output reg [3:0] s_axi_wstrb,
   output reg s_axi_wvalid,
   input wire s_axi_wready,
   input wire [1:0] s_axi_bresp,
   input wire s_axi_bvalid,
   output reg s_axi_bready,
   // read side
   output reg [5:0] s_axi_araddr,
   output reg s_axi_arvalid,
   input wire s_axi_arready,
   input wire [31:0] s_axi_rdata,
   input wire [1:0] s_axi_rresp,
   input wire s_axi_rvalid,
   output reg s_axi_rready
);
   // idle bus at time zero
   initial begin
      {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid} = 0;
      {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = 0;
   end
   // handshakes judged at the rising edge, on the values the slave samples there
   task wr(input [5:0] a, input [31:0] d, output [1:0] r);
      reg aw_t, w_t, done;
      begin
         done = 0;
         @(posedge aclk);
         {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, d, 4'hf};
         {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
         while (!done) begin
            @(posedge aclk);
            aw_t = s_axi_awvalid && s_axi_awready;
            w_t = s_axi_wvalid && s_axi_wready;
            done = s_axi_bvalid;
            r = s_axi_bresp;
            if (aw_t) s_axi_awvalid <= 1'b0;
            if (w_t) s_axi_wvalid <= 1'b0;
            if (done) s_axi_bready <= 1'b0;
         end
      end
   endtask
   task rd(input [5:0] a, output [31:0] d, output [1:0] r);
      reg ar_t, done;
      begin
         done = 0;
         @(posedge aclk);
         s_axi_araddr <= a;
         {s_axi_arvalid, s_axi_rready} <= 2'h3;
         while (!done) begin
            @(posedge aclk);
            ar_t = s_axi_arvalid && s_axi_arready;
            done = s_axi_rvalid;
            {d, r} = {s_axi_rdata, s_axi_rresp};
            if (ar_t) s_axi_arvalid <= 1'b0;
            if (done) s_axi_rready <= 1'b0;
         end
      end
   endtask
endmodule

// >>> tb/tb_general_timer_module.sv
// self-checking bench for the general timer module
`timescale 1ns/1ps
`include "gtm_defs.vh"
module tb_general_timer_module;
   reg aclk, aresetn, high_clk_tick, timebase_tick, ext_count_clock_pin, capture_input_pin;
   wire timer_output_pin, timer_output_pin_en, timer_output_pin_inverted;
   wire timer_output_pin_inverted_en, irq_compare_a, irq_compare_p;
   wire [5:0] s_axi_awaddr, s_axi_araddr;
   wire [31:0] s_axi_wdata, s_axi_rdata;
   wire [3:0] s_axi_wstrb;
   wire [1:0] s_axi_bresp, s_axi_rresp;
   wire s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   wire s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   int miscompares, checks_done, cyc, n, i;
   reg [31:0] d;
   reg [1:0] r;
   gtm_timer dut_u (.aclk, .aresetn, .high_clk_tick, .timebase_tick, .ext_count_clock_pin,
      .capture_input_pin, .timer_output_pin, .timer_output_pin_en, .timer_output_pin_inverted,
      .timer_output_pin_inverted_en, .irq_compare_a, .irq_compare_p, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
   gtm_axi_master m_u (.aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready);
   task finish_test;
      if (miscompares == 0 && checks_done > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task chk(input [31:0] got, input [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task wr_ok(input [5:0] a, input [31:0] v);
      m_u.wr(a, v, r);
      chk(r, 0);
   endtask
   task rd_chk(input [5:0] a, input [31:0] e);
      m_u.rd(a, d, r);
      chk(d, e);
   endtask
   task clks(input int k);
      repeat (k) @(posedge aclk);
   endtask
   // slow pin pulses; sync delay is three cycles, so four high and four low
   task pulse_ext(input int k);
      repeat (k) begin
         ext_count_clock_pin <= 1'b1;
         clks(4);
         ext_count_clock_pin <= 1'b0;
         clks(4);
      end
   endtask
   // cycles until the chosen request is seen, bounded
   task wait_irq(input int sel, output int k);
      k = 0;
      do begin
         @(negedge aclk);
         k++;
      end while ((sel ? irq_compare_p : irq_compare_a) !== 1'b1 && k < 3000);
   endtask
   initial begin
      aclk = 0;
      forever #10 aclk = ~aclk;
   end
   // hang guard; the whole run needs some sixteen hundred cycles
   always @(posedge aclk) begin
      high_clk_tick <= ~high_clk_tick;
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         miscompares++;
         finish_test;
      end
   end
   initial begin
      {aresetn, high_clk_tick, timebase_tick, ext_count_clock_pin, capture_input_pin} = 0;
      {miscompares, checks_done, cyc} = 0;
      clks(10);
      aresetn <= 1'b1;
      for (i = 0; i < 4; i++) rd_chk(i < 2 ? i * 4 : 6'h10 + i * 4, 0);
      m_u.rd(6'h20, d, r);
      chk(d, 0);
      chk(r, 2);
      m_u.wr(6'h3c, 32'hff, r);
      chk(r, 2);
      wr_ok(`GTM_OFF_CMPL, 32'h5a);
      rd_chk(`GTM_OFF_CMPL, 32'h5a);
      rd_chk(`GTM_OFF_CMPH, 0);
      rd_chk(`GTM_OFF_CMPL, 0);
      wr_ok(`GTM_OFF_CMPL, 32'ha5);
      wr_ok(`GTM_OFF_CMPH, 32'h2);
      rd_chk(`GTM_OFF_CMPH, 2);
      rd_chk(`GTM_OFF_CMPL, 32'ha5);
      rd_chk(`GTM_OFF_CNTH, 0);
      rd_chk(`GTM_OFF_CMPL, 0);
      // external clock counting, on-bit clearing, gating
      wr_ok(`GTM_OFF_CTRL0, 8'h60);
      wr_ok(`GTM_OFF_PINSEL, 1);
      wr_ok(`GTM_OFF_CTRL0, 8'h68);
      pulse_ext(5);
      rd_chk(`GTM_OFF_CNTH, 0);
      rd_chk(`GTM_OFF_CNTL, 5);
      wr_ok(`GTM_OFF_CTRL0, 8'h70);
      rd_chk(`GTM_OFF_CNTH, 0);
      rd_chk(`GTM_OFF_CNTL, 5);
      wr_ok(`GTM_OFF_CTRL0, 8'h78);
      rd_chk(`GTM_OFF_CNTH, 0);
      rd_chk(`GTM_OFF_CNTL, 0);
      pulse_ext(3);
      rd_chk(`GTM_OFF_CNTH, 0);
      rd_chk(`GTM_OFF_CNTL, 3);
      wr_ok(`GTM_OFF_CTRL0, 8'h48);
      pulse_ext(2);
      rd_chk(`GTM_OFF_CNTH, 0);
      rd_chk(`GTM_OFF_CNTL, 3);
      // timebase selected: each one-cycle tick advances the count once
      repeat (4) begin
         timebase_tick <= 1'b1;
         clks(1);
         timebase_tick <= 1'b0;
         clks(1);
      end
      rd_chk(`GTM_OFF_CNTH, 0);
      rd_chk(`GTM_OFF_CNTL, 7);
      wr_ok(`GTM_OFF_CTRL0, 8'h78);
      wr_ok(`GTM_OFF_PINSEL, 0);
      pulse_ext(2);
      rd_chk(`GTM_OFF_CNTH, 0);
      rd_chk(`GTM_OFF_CNTL, 7);
      // period and compare a in timer mode, system clock
      wr_ok(`GTM_OFF_CTRL0, 0);
      wr_ok(`GTM_OFF_CTRL1, 8'hc0);
      wr_ok(`GTM_OFF_CMPL, 32'h40);
      wr_ok(`GTM_OFF_CMPH, 0);
      wr_ok(`GTM_OFF_CTRL0, 8'h19);
      wait_irq(1, n);
      wait_irq(1, n);
      chk(n >= 128 && n <= 129, 1);
      wait_irq(0, n);
      chk(n >= 64 && n <= 65, 1);
      // compare output: low, high, toggle; a match clears
      wr_ok(`GTM_OFF_PINSEL, 32'hc);
      for (i = 1; i < 4; i++) begin
         wr_ok(`GTM_OFF_CTRL0, 8'h11);
         wr_ok(`GTM_OFF_CTRL1, (i << 4) | 1);
         wr_ok(`GTM_OFF_CTRL0, 8'h19);
         // pin is registered behind out_q, so let the on-bit reset reach it
         clks(2);
         chk(timer_output_pin, 0);
         wait_irq(0, n);
         clks(2);
         chk(timer_output_pin, i != 1);
      end
      wait_irq(0, n);
      clks(2);
      chk(timer_output_pin, 0);
      chk({timer_output_pin_en, timer_output_pin_inverted_en}, 3);
      // pwm: period 128 by p, duty 32 by a
      wr_ok(`GTM_OFF_CTRL0, 8'h11);
      wr_ok(`GTM_OFF_CTRL1, 8'ha0);
      wr_ok(`GTM_OFF_CMPL, 32'h20);
      wr_ok(`GTM_OFF_CMPH, 0);
      wr_ok(`GTM_OFF_CTRL0, 8'h19);
      clks(300);
      n = 0;
      repeat (256) @(negedge aclk) n += timer_output_pin;
      chk((n >= 62 && n <= 66) || (n >= 190 && n <= 194), 1);
      // capture edges: rising, falling, both
      wr_ok(`GTM_OFF_PINSEL, 2);
      for (i = 0; i < 3; i++) begin
         wr_ok(`GTM_OFF_CTRL1, 8'h40 | (i << 4));
         wr_ok(`GTM_OFF_STAT, 7);
         capture_input_pin <= 1'b1;
         clks(6);
         m_u.rd(`GTM_OFF_STAT, d, r);
         chk(d[2], i != 1);
         wr_ok(`GTM_OFF_STAT, 7);
         capture_input_pin <= 1'b0;
         clks(6);
         m_u.rd(`GTM_OFF_STAT, d, r);
         chk(d[2], i != 0);
      end
      finish_test;
   end
endmodule
